//--- ebcs_consts.vh
// Constants for the card-slot clocking and access block
`ifndef EBCS_CONSTS_VH
`define EBCS_CONSTS_VH
`define EBCS_DIV_1 2'h0
`define EBCS_DIV_2 2'h1
`define EBCS_DIV_3 2'h2
`define EBCS_DIV_4 2'h3
`define EBCS_STRAP_LSB 3
`define EBCS_STRAP_MSB 4
`define EBCS_PSIZE_32 2'h0
`define EBCS_PSIZE_8 2'h1
`define EBCS_PSIZE_16 2'h2
`define EBCS_SPACE_ATTR 2'h0
`define EBCS_SPACE_MEM 2'h1
`define EBCS_SPACE_IO 2'h2
`define EBCS_NCH 8
`define EBCS_ADDR_W 26
`define EBCS_PIN_ADDR_W 20
`define EBCS_UPPER_W 6
`endif

//--- ebcs_clkdiv.v
// Clock divider producing a rate enable and a divided clock level
`timescale 1ns/1ns
`include "ebcs_consts.vh"
module ebcs_clkdiv (
  input wire ref_clk_i, // Internal bus clock
  input wire rst_i, // Async reset, active high
  input wire [1:0] ratio_i, // 0..3 means 1/1..1/4
  output reg tick_o, // One-cycle pulse at divided rate
  output reg clk_o // Divided clock level
);
  reg [1:0] cnt_q;
  wire last = (cnt_q >= ratio_i);
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      tick_o <= 1'b0;
      clk_o <= 1'b0;
    end else begin
      cnt_q <= last ? 2'h0 : cnt_q + 2'h1;
      tick_o <= last;
      // High for the first half of each divided period, first two of three at 1/3; 1/1 toggles every cycle
      if (ratio_i == `EBCS_DIV_1)
        clk_o <= ~clk_o;
      else
        clk_o <= (last || cnt_q < (ratio_i >> 1));
    end
  end
endmodule

//--- ebcs_card_ctrl.v
// Card-mode access sequencer with clock division for one channel group
`timescale 1ns/1ns
`include "ebcs_consts.vh"
// Behaviour
// - System clock output runs at 1/1, 1/2, 1/3 or 1/4 of bus clock.
// - Divide ratio strapped from address bits 4:3 at reset, reported out.
// - Per-channel operation clock ratio from its speed field, independent.
// - Channel external signals change on that channel's clock tick, and on every cycle while idle.
// - Two slots supported; any of eight channels may target either.
// - Card mode only with non-zero card-mode field; gates slot routing.
// - Slot select 0 drives slot 1 enables, 1 drives slot 2.
// - Chip enable and byte enables keep cycling in card mode, OE and WE only outside IO space.
// - OE and WE held inactive during card IO accesses.
// - IO read and write strobes multiplexed onto byte enable pins 3 and 2.
// - Attribute, common and IO spaces via register select and IO strobes.
// - Page or external-ack mode with card mode gives undefined results.
// - Card addressing valid only with 8-bit or 16-bit port size.
// - Card mode uses setup/hold wait states around strobes.
// - Page-wait and wait counts lengthen strobe active time.
// - Ready option inserts waits until the slot's wait input goes inactive.
// - Wait input sampled only after the programmed wait count elapsed.
// - Wait inputs synchronised to full-speed internal clock.
// - Upper 6 address bits presented for latching under upper-address enable.
// - Card mode always outputs byte addresses for 8 and 16-bit ports.
// - No dynamic IO sizing; width fixed by configuration.
// - No burst cycles on card-mode channels.
// - Ready input checked only after programmed wait count.
module ebcs_card_ctrl (
  input wire ref_clk_i, // Internal bus clock, 100 MHz
  input wire rst_i, // Async reset, active high
  input wire [19:0] addr_pin_i, // Address pins, strap read at reset
  output reg [1:0] sys_clock_divide_field_o, // Strapped ratio report
  output wire ext_sys_clock_out_o, // Divided system clock
  input wire req_i, // Access request, level until ack
  input wire [2:0] req_ch_i, // Channel of the request
  input wire req_write_i, // 1 write, 0 read
  input wire [25:0] req_addr_i, // Byte address of the access
  input wire [1:0] req_be_i, // Lanes wanted: bit1 high byte, bit0 low byte
  output wire req_ack_o, // Access done, one-cycle pulse
  input wire [15:0] channel_speed_field_i, // 2 bits per channel
  input wire [15:0] card_mode_field_i, // 2 bits per channel, 0 is off
  input wire [7:0] slot_select_bit_i, // Per channel slot, 0 slot 1
  input wire [15:0] card_space_i, // 2 bits per channel: attr/mem/io
  input wire [15:0] port_size_i, // 2 bits per channel
  input wire [7:0] setup_hold_wait_option_i, // Per channel, 1 enables
  input wire [15:0] page_wait_count_i, // 2 bits per channel
  input wire [31:0] wait_count_i, // 4 bits per channel
  input wire [7:0] ready_option_i, // Per channel ready mode
  input wire [7:0] page_mode_i, // Per channel page mode
  input wire [7:0] ext_ack_mode_i, // Per channel external ack mode
  input wire [7:0] burst_i, // Request is a burst, per channel
  input wire slot1_wait_n_i, // Slot 1 card wait, active low
  input wire slot2_wait_n_i, // Slot 2 card wait, active low
  output reg [7:0] chip_enable_n_o, // Channel chip enables
  output reg oe_n_o, // Memory output enable
  output reg we_n_o, // Memory write enable
  output reg [3:0] byte_write_enables_n_o, // Byte enables, 3:2 carry IO strobes
  output reg [1:0] slot1_card_enables_n_o, // Slot 1 high/low enables
  output reg [1:0] slot2_card_enables_n_o, // Slot 2 high/low enables
  output reg card_register_select_n_o, // Low for attribute and IO space
  output reg [19:0] addr_o, // External address
  output reg upper_address_latch_enable_o, // Latch strobe for address bits 25:20
  output reg cfg_error_o // Card mode with illegal config
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_STROBE = 3'h2;
  localparam ST_WAITRDY = 3'h3;
  localparam ST_HOLD = 3'h4;
  localparam ST_UPPER = 3'h5;
  localparam ST_DONE = 3'h6;

  function [1:0] fld2;
    input [15:0] v;
    input [2:0] ch;
    begin
      fld2 = v[ch*2 +: 2];
    end
  endfunction

  // External address for one access
  function [19:0] ext_addr;
    input [25:0] a;
    input card_ch;
    input [1:0] size;
    begin
      // Card channels keep byte addresses; others scale by port size
      if (card_ch || size == `EBCS_PSIZE_8)
        ext_addr = a[19:0];
      else if (size == `EBCS_PSIZE_16)
        ext_addr = {1'b0, a[19:1]};
      else
        ext_addr = {2'h0, a[19:2]};
    end
  endfunction

  // Strap pins are asynchronous; no reset so the chain fills while reset holds
  reg [1:0] strap_s0_q;
  reg [1:0] strap_s1_q;
  reg [1:0] strap_s2_q;
  always @(posedge ref_clk_i) begin
    strap_s0_q <= addr_pin_i[`EBCS_STRAP_MSB:`EBCS_STRAP_LSB];
    strap_s1_q <= strap_s0_q;
    strap_s2_q <= strap_s1_q;
  end
  wire strap_stable = (strap_s1_q == strap_s2_q);

  // Strap capture on the clock after release
  reg strap_done_q;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_done_q <= 1'b0;
      sys_clock_divide_field_o <= `EBCS_DIV_1;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      if (strap_stable)
        sys_clock_divide_field_o <= strap_s2_q;
    end
  end

  wire sys_div_clk;
  ebcs_clkdiv u_sysdiv (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ratio_i(sys_clock_divide_field_o),
    .tick_o(),
    .clk_o(sys_div_clk)
  );

  // No flop can toggle at the bus rate, so 1/1 passes the bus clock on.
  // The select moves only at strap time, right after reset.
  assign ext_sys_clock_out_o = (sys_clock_divide_field_o == `EBCS_DIV_1) ?
                               ref_clk_i : sys_div_clk;

  reg [2:0] ch_q;
  wire [1:0] ch_speed = fld2(channel_speed_field_i, ch_q);
  wire ch_tick;
  ebcs_clkdiv u_chdiv (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ratio_i(ch_speed),
    .tick_o(ch_tick),
    .clk_o()
  );

  // Wait inputs: three flops, change accepted when last two agree
  reg [2:0] w1_q;
  reg [2:0] w2_q;
  reg w1_act_q;
  reg w2_act_q;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      w1_q <= 3'h7;
      w2_q <= 3'h7;
      w1_act_q <= 1'b0;
      w2_act_q <= 1'b0;
    end else begin
      w1_q <= {w1_q[1:0], slot1_wait_n_i};
      w2_q <= {w2_q[1:0], slot2_wait_n_i};
      if (w1_q[2] == w1_q[1])
        w1_act_q <= ~w1_q[2];
      if (w2_q[2] == w2_q[1])
        w2_act_q <= ~w2_q[2];
    end
  end

  reg [2:0] st_q;
  reg [5:0] cnt_q;
  reg wr_q;
  reg [25:0] a_q;
  reg [1:0] be_q;
  reg ack_q;
  reg [2:0] nch;
  wire card = (fld2(card_mode_field_i, ch_q) != 2'h0);
  wire slot2 = slot_select_bit_i[ch_q];
  wire [1:0] space = fld2(card_space_i, ch_q);
  wire is_io = card && (space == `EBCS_SPACE_IO);
  wire [1:0] psz = fld2(port_size_i, ch_q);
  wire shw = setup_hold_wait_option_i[ch_q] || card;
  wire [5:0] wcnt = {page_wait_count_i[ch_q*2 +: 2], wait_count_i[ch_q*4 +: 4]};
  wire rdy = ready_option_i[ch_q];
  wire wait_act = slot2 ? w2_act_q : w1_act_q;
  wire cfg_mode_bad = page_mode_i[ch_q] || ext_ack_mode_i[ch_q];
  wire cfg_size_bad = (psz == `EBCS_PSIZE_32);
  wire cfg_burst_bad = burst_i[ch_q];
  // Flag only: the access still runs, its result is undefined
  wire bad_cfg = card && (cfg_mode_bad || cfg_size_bad || cfg_burst_bad);

  assign req_ack_o = ack_q;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 6'h00;
      ch_q <= 3'h0;
      wr_q <= 1'b0;
      a_q <= 26'h0000000;
      be_q <= 2'h0;
      ack_q <= 1'b0;
      cfg_error_o <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (req_i && !ack_q) begin
            ch_q <= req_ch_i;
            wr_q <= req_write_i;
            a_q <= req_addr_i;
            be_q <= req_be_i;
            st_q <= ST_UPPER;
          end
        end
        ST_UPPER: begin
          cfg_error_o <= bad_cfg;
          if (ch_tick)
            st_q <= shw ? ST_SETUP : ST_STROBE;
          cnt_q <= wcnt;
        end
        ST_SETUP: begin
          if (ch_tick)
            st_q <= ST_STROBE;
        end
        ST_STROBE: begin
          if (ch_tick) begin
            if (cnt_q != 6'h00)
              cnt_q <= cnt_q - 6'h01;
            else if (rdy)
              st_q <= ST_WAITRDY;
            else
              st_q <= shw ? ST_HOLD : ST_DONE;
          end
        end
        ST_WAITRDY: begin
          // Wait read only after the count; early high would end too soon
          if (ch_tick && !(card ? wait_act : 1'b0))
            st_q <= shw ? ST_HOLD : ST_DONE;
        end
        ST_HOLD: begin
          if (ch_tick)
            st_q <= ST_DONE;
        end
        ST_DONE: begin
          if (ch_tick) begin
            ack_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Pin outputs registered; updated on the channel tick and on every cycle in idle
  wire active = (st_q == ST_SETUP) || (st_q == ST_STROBE) ||
                (st_q == ST_WAITRDY) || (st_q == ST_HOLD);
  wire strobe = (st_q == ST_STROBE) || (st_q == ST_WAITRDY);
  wire [1:0] lanes_n = (psz == `EBCS_PSIZE_8) ? 2'h2 : ~be_q;
  always @* begin
    nch = ch_q;
  end
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chip_enable_n_o <= 8'hff;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      byte_write_enables_n_o <= 4'hf;
      slot1_card_enables_n_o <= 2'h3;
      slot2_card_enables_n_o <= 2'h3;
      card_register_select_n_o <= 1'b1;
      addr_o <= 20'h00000;
      upper_address_latch_enable_o <= 1'b0;
    end else if (ch_tick || st_q == ST_IDLE) begin
      chip_enable_n_o <= 8'hff;
      if (active)
        chip_enable_n_o[nch] <= 1'b0;
      oe_n_o <= ~(strobe && !wr_q && !is_io);
      we_n_o <= ~(strobe && wr_q && !is_io);
      byte_write_enables_n_o <= 4'hf;
      if (strobe) begin
        if (is_io) begin
          byte_write_enables_n_o[3] <= wr_q;
          byte_write_enables_n_o[2] <= ~wr_q;
        end else begin
          byte_write_enables_n_o[1:0] <= ~be_q;
        end
      end
      slot1_card_enables_n_o <= (active && card && !slot2) ? lanes_n : 2'h3;
      slot2_card_enables_n_o <= (active && card && slot2) ? lanes_n : 2'h3;
      card_register_select_n_o <= ~(active && card && space != `EBCS_SPACE_MEM);
      if (st_q == ST_UPPER) begin
        addr_o <= {14'h0000, a_q[25:20]};
        upper_address_latch_enable_o <= card;
      end else begin
        upper_address_latch_enable_o <= 1'b0;
        if (active)
          addr_o <= ext_addr(a_q, card, psz);
      end
    end
  end
endmodule

//--- ebcs_card_slot.sv
// Card slot model driving one wait line
`timescale 1ns/1ns
module ebcs_card_slot (
  input wire ref_clk_i, // Clock
  input wire [1:0] card_en_n_i, // Enables, low on
  input wire [7:0] hold_i, // Wait span, 0 answers at once
  output reg wait_n_o // Wait, low active
);
  reg [7:0] cnt_q;
  initial begin
    cnt_q = 8'h0;
    wait_n_o = 1'b1;
  end
  always @(posedge ref_clk_i) begin
    if (&card_en_n_i) begin
      cnt_q <= 8'h0;
      wait_n_o <= 1'b1; // Pull-up once deselected
    end else begin
      cnt_q <= cnt_q + 8'h1;
      wait_n_o <= (cnt_q >= hold_i);
    end
  end
endmodule

//--- ebcs_card_ctrl_sva.sv
// Port checker for the card access block
`timescale 1ns/1ns
`include "ebcs_consts.vh"
module ebcs_card_ctrl_chk (
  input wire ref_clk_i, // Clock
  input wire rst_i, // Reset
  input wire [19:0] addr_pin_i, // Straps
  input wire [1:0] sys_clock_divide_field_o, // Ratio
  input wire req_i, // Request
  input wire [2:0] req_ch_i, // Channel
  input wire req_write_i, // Write
  input wire [25:0] req_addr_i, // Address
  input wire req_ack_o, // Done
  input wire [15:0] card_mode_field_i, // Card mode
  input wire [7:0] slot_select_bit_i, // Slot
  input wire [15:0] card_space_i, // Space
  input wire oe_n_o, // OE
  input wire we_n_o, // WE
  input wire [3:0] byte_write_enables_n_o, // Lanes
  input wire [1:0] slot1_card_enables_n_o, // Slot 1
  input wire [1:0] slot2_card_enables_n_o, // Slot 2
  input wire [19:0] addr_o, // Address
  input wire upper_address_latch_enable_o // Upper
);
  wire on1 = slot1_card_enables_n_o != 2'h3;
  wire on2 = slot2_card_enables_n_o != 2'h3;
  wire cm = card_mode_field_i[2*req_ch_i +: 2] != 2'h0;
  wire io = req_i && cm && card_space_i[2*req_ch_i +: 2] == `EBCS_SPACE_IO;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_take; $past(rst_i) |=> sys_clock_divide_field_o == $past(addr_pin_i[4:3]); endproperty
  a_take: assert property (p_take) else $error("ratio not strapped");
  property p_keep; !$past(rst_i, 2) |-> $stable(sys_clock_divide_field_o); endproperty
  a_keep: assert property (p_keep) else $error("ratio moved");
  property p_route; on1 || on2 |-> on1 != on2 && on2 == slot_select_bit_i[req_ch_i]; endproperty
  a_route: assert property (p_route) else $error("wrong slot");
  property p_card; on1 || on2 |-> cm && req_i; endproperty
  a_card: assert property (p_card) else $error("slot without card mode");
  property p_idle; req_ack_o |=> !on1 && !on2; endproperty
  a_idle: assert property (p_idle) else $error("slot left on");
  property p_io; io |-> oe_n_o && we_n_o; endproperty
  a_io: assert property (p_io) else $error("strobe in io");
  property p_iord; io && !byte_write_enables_n_o[3] |-> !req_write_i; endproperty
  a_iord: assert property (p_iord) else $error("io read on write");
  property p_uae; upper_address_latch_enable_o |-> addr_o[5:0] == req_addr_i[25:20]; endproperty
  a_uae: assert property (p_uae) else $error("upper address");
  property p_byte; on1 || on2 |-> addr_o == req_addr_i[19:0]; endproperty
  a_byte: assert property (p_byte) else $error("byte address");
  c_s1: cover property (on1);
  c_s2: cover property (on2);
  c_io: cover property (io && !byte_write_enables_n_o[2]);
endmodule
bind ebcs_card_ctrl ebcs_card_ctrl_chk u_chk (.*);

//--- test_ext_bus_card_slot_clocking.sv
// Bench for the card access block
`timescale 1ns/1ns
`include "ebcs_consts.vh"
module test_ext_bus_card_slot_clocking;
  reg ref_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [19:0] ap = 20'h0;
  reg rq = 1'b0, rw = 1'b0;
  reg [2:0] rc = 3'h0;
  reg [25:0] ra = 26'h0;
  reg [1:0] rb = 2'h3;
  reg [15:0] sp = 16'h4000, cmd = 16'hf000, spc = 16'h5555, ps = 16'haaaa;
  reg [31:0] wc = 32'h20000000;
  reg [7:0] sel = 8'h80, rdy = 8'hc0, h1 = 8'h0, z = 8'h0, pm = 8'h0;
  wire w1, w2, sck, ack, oe, we, upper_address_latch_enable, rs, cfe;
  wire [1:0] sdiv, s1, s2;
  wire [7:0] ce;
  wire [3:0] bw;
  wire [19:0] ao;
  int num_errors = 0, n_checks = 0, lat, l6;
  reg [1:0] m1, m2;
  reg [3:0] mb;
  reg mo, mw, mr;
  reg [7:0] mce;
  reg [5:0] mu;
  reg [19:0] ma;
  time t0;
  always #5 ref_clk_i = ~ref_clk_i;
  ebcs_card_ctrl DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_pin_i(ap),
    .sys_clock_divide_field_o(sdiv), .ext_sys_clock_out_o(sck), .req_i(rq), .req_ch_i(rc),
    .req_write_i(rw), .req_addr_i(ra), .req_be_i(rb), .req_ack_o(ack),
    .channel_speed_field_i(sp), .card_mode_field_i(cmd), .slot_select_bit_i(sel),
    .card_space_i(spc), .port_size_i(ps), .setup_hold_wait_option_i(8'hc0),
    .page_wait_count_i(16'h0), .wait_count_i(wc), .ready_option_i(rdy), .page_mode_i(pm),
    .ext_ack_mode_i(z), .burst_i(z), .slot1_wait_n_i(w1), .slot2_wait_n_i(w2),
    .chip_enable_n_o(ce), .oe_n_o(oe), .we_n_o(we), .byte_write_enables_n_o(bw),
    .slot1_card_enables_n_o(s1), .slot2_card_enables_n_o(s2), .card_register_select_n_o(rs),
    .addr_o(ao), .upper_address_latch_enable_o(upper_address_latch_enable), .cfg_error_o(cfe));
  ebcs_card_slot u_s1 (.ref_clk_i(ref_clk_i), .card_en_n_i(s1), .hold_i(h1), .wait_n_o(w1));
  ebcs_card_slot u_s2 (.ref_clk_i(ref_clk_i), .card_en_n_i(s2), .hold_i(z), .wait_n_o(w2));
  task close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input [19:0] e, input [19:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task step;
    @(posedge ref_clk_i);
    #1;
  endtask
  // Accumulate lows seen on each pin over one access
  task acc(input [2:0] c, input w, input [25:0] a, input [1:0] b);
    {m1, m2, mb, mo, mw, mr, mce, mu, ma} = {2'h3, 2'h3, 4'hf, 3'h7, 8'hff, 26'h0};
    lat = 0;
    {rc, rw, ra, rb, rq} = {c, w, a, b, 1'b1};
    while (ack !== 1'b1 && lat < 300) begin
      step;
      lat++;
      {m1, m2, mb, mo, mw, mr, mce} = {m1, m2, mb, mo, mw, mr, mce} & {s1, s2, bw, oe, we, rs, ce};
      if (upper_address_latch_enable) mu = ao[5:0];
      if (s1 != 2'h3 || s2 != 2'h3) ma = ao;
    end
    rq = 1'b0;
    if (lat == 300) chk("ack", 1, 0);
    step;
  endtask
  task t_strap;
    for (int r = 0; r < 4; r++) begin
      rst_i = 1'b1;
      ap = {15'h0, r[1:0], 3'h0};
      repeat (6) step;
      rst_i = 1'b0;
      repeat (3) step;
      ap = 20'hfffff;
      chk("ratio", r, sdiv);
      @(posedge sck) t0 = $time;
      @(posedge sck);
      chk("period", (r + 1) * 10, 20'($time - t0));
      step;
    end
  endtask
  task t_route;
    acc(3'h6, 1'b0, 26'h2c12346, 2'h3);
    chk("s1", 0, m1);
    chk("s2", 3, m2);
    chk("ce", 0, mce[6]);
    chk("oe", 0, mo);
    chk("upper", 6'h2c, mu);
    chk("addr", 20'h12346, ma);
    l6 = lat;
    acc(3'h7, 1'b1, 26'h1312344, 2'h1);
    chk("s2", 2, m2);
    chk("s1", 3, m1);
    chk("we", 0, mw);
    chk("slow", 1, lat > l6);
  endtask
  task t_space;
    for (int s = 0; s < 3; s++) begin
      for (int w = 0; w < 2; w++) begin
        spc[13:12] = s[1:0];
        acc(3'h6, w[0], 26'h0000100, 2'h3);
        chk("regsel", s == 1, mr);
        if (s == 2) begin
          chk("oe", 1, mo);
          chk("we", 1, mw);
          chk("iord", w, mb[3]);
          chk("iowr", w == 0, mb[2]);
        end else chk("strobe", 0, w ? mw : mo);
      end
    end
    spc = 16'h5555;
  endtask
  task t_other;
    acc(3'h5, 1'b0, 26'h0000010, 2'h3);
    chk("none", 4'hf, {m1, m2});
    chk("ce", 0, mce[5]);
    pm = 8'h40;
    acc(3'h6, 1'b0, 26'h0000012, 2'h3);
    chk("cfgerr", 1, cfe);
    pm = 8'h00;
    acc(3'h6, 1'b0, 26'h0000012, 2'h3);
    chk("cfgok", 0, cfe);
    ps[13:12] = 2'h1;
    acc(3'h6, 1'b0, 26'h0000011, 2'h1);
    chk("lane8", 2, m1);
    chk("addr8", 20'h00011, ma);
    ps = 16'haaaa;
  endtask
  // Wait count covers the sync delay, else the cycle may end early
  task t_wait;
    wc[27:24] = 4'h6;
    h1 = 8'd30;
    acc(3'h6, 1'b0, 26'h0000200, 2'h3);
    chk("waited", 1, lat > 30);
    h1 = 8'h0;
    acc(3'h6, 1'b0, 26'h0000200, 2'h3);
    chk("nowait", 1, lat < 30);
  endtask
  initial begin
    #200000;
    num_errors++;
    close_out;
  end
  initial begin
    t_strap;
    t_route;
    t_space;
    t_other;
    t_wait;
    close_out;
  end
endmodule
